// [src/brc_sequencer.sv]
// Purpose: Burst read configuration register and the burst address sequencer.
// Assumes: Burst clock is sampled by mclk_i; command decode supplies cfg writes.
// Notes:   Reads one double-word address per beat out to the array port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Configuration holds until rewrite or reset.
// - Read-mode bit one async, zero burst.
// - Reset forces read-mode bit to one.
// - Latency codes 010..110 give 4..8 cycles.
// - Inter-beat bit chooses one or two cycles.
// - Ready-timing bit drops ready one cycle early.
// - Interleaved order XORs beat count into offset.
// - Sequential wrap increments modulo length in group.
// - Edge bit selects falling or rising clock.
// - Wrap-disable bit lets addresses cross group.
// - Length codes give four, eight, continuous.
// - Aligned unbounded bursts never drop ready.
// - Unaligned unbounded bursts drop ready for refill.
// - Ready low stalls data and counter.
// - Continuous burst rolls over to zero.
// - Start address latched on first edge or latch rise.
// - Signature read at five returns configuration.
module brc_sequencer #(
  parameter int AW = 19
) (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  // Device pins (asynchronous to mclk_i)
  input  wire logic                      burst_clk_i,
  input  wire logic                      chip_en_n_i,
  input  wire logic                      latch_en_n_i,
  input  wire logic                      burst_adv_n_i,
  input  wire logic                      reset_powerdown_n_i,
  input  wire logic [AW-1:0]             addr_i,
  // Configuration write from the command decoder (same clock)
  input  wire logic                      cfg_wr_i,
  input  wire logic [brc_pkg::CFG_W-1:0] cfg_wdata_i,
  // Signature read mode flag from the command decoder (same clock)
  input  wire logic                      sig_mode_i,
  // Status and array side
  output logic [brc_pkg::CFG_W-1:0]      burst_read_config_o,
  output logic                           async_mode_o,
  output logic                           sig_cfg_sel_o,
  output logic [AW-1:0]                  beat_addr_o,
  output logic                           beat_valid_o,
  output logic                           data_ready_o
);
  import brc_pkg::*;

  typedef enum logic [1:0] {
    BRC_IDLE  = 2'b00,
    BRC_LAT   = 2'b01,
    BRC_BURST = 2'b10
  } brc_state_t;

  // ==========================================================================
  // Synchronised pins
  logic          k_s, ce_n_s, l_n_s, b_n_s, rp_n_s;
  logic [AW-1:0] a_s;

  // Pins idle high (clock parked, strobes inactive), address idles at zero.
  brc_sync2 #(.W(AW + 5), .RST({5'b11111, AW'(0)})) u_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({burst_clk_i, chip_en_n_i, latch_en_n_i, burst_adv_n_i,
                 reset_powerdown_n_i, addr_i}),
    .q_o       ({k_s, ce_n_s, l_n_s, b_n_s, rp_n_s, a_s})
  );

  // ==========================================================================
  // State
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic             k_d_r, l_d_r;
  brc_state_t       st_r, st_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [AW-1:0]    start_r, start_nxt;
  logic [2:0]       beat_r, beat_nxt;
  logic [AW-1:0]    lin_r, lin_nxt;
  logic [AW-1:0]    addr_r, addr_nxt;
  logic             vld_r, vld_nxt;
  logic             rdy_r, rdy_nxt;
  logic             gap_r, gap_nxt;
  logic             refill_done_r, refill_done_nxt;

  // ==========================================================================
  // Decoded fields and edge detection
  logic       act_edge, latch_rise, aligned8, unbounded;
  logic [2:0] fal, blf;
  logic [2:0] beat_sel;
  logic [3:0] lat_cyc;
  logic [2:0] len_mask;
  logic [AW-1:0] seq_addr, next_lin;

  assign fal       = cfg_r[FAL_HI:FAL_LO];
  assign blf       = cfg_r[BLF_HI:0];
  // Falling edge when the edge bit is zero, rising when one.
  assign act_edge  = cfg_r[CES_BIT] ? (k_s & ~k_d_r) : (~k_s & k_d_r);
  assign latch_rise = l_n_s & ~l_d_r;
  // Code 010 maps to four cycles, each step adds one.
  assign lat_cyc   = FAL_BASE_CYC + 4'(fal - FAL_BASE);
  assign len_mask  = (blf == BLF_LEN8) ? 3'h7 : 3'h3;
  assign unbounded = (blf == BLF_CONT) | cfg_r[WRD_BIT];
  assign aligned8  = (start_r[2:0] == 3'h0);

  // ==========================================================================
  // Beat address generation.
  always_comb begin
    next_lin = lin_r + AW'(1);
    // In a burst the address is formed for the beat about to be issued.
    beat_sel = (st_r == BRC_BURST) ? 3'(beat_r + 3'h1) : beat_r;
    if (unbounded) begin
      seq_addr = lin_r;
    end else if (cfg_r[BOS_BIT]) begin
      // Sequential wrap stays inside the aligned group.
      seq_addr = {start_r[AW-1:3],
                  (start_r[2:0] & ~len_mask) | ((start_r[2:0] + beat_sel) & len_mask)};
    end else begin
      seq_addr = {start_r[AW-1:3],
                  (start_r[2:0] & ~len_mask) | ((start_r[2:0] ^ beat_sel) & len_mask)};
    end
  end

  // ==========================================================================
  // Configuration register next value. Device reset or power-down restores it.
  always_comb begin
    cfg_nxt = cfg_r;
    if (!rp_n_s) begin
      cfg_nxt = CFG_RESET;
    end else if (cfg_wr_i) begin
      cfg_nxt = cfg_wdata_i & CFG_WRITE_MASK;
    end
  end

  // ==========================================================================
  // Burst sequencer next state.
  always_comb begin
    st_nxt          = st_r;
    cnt_nxt         = cnt_r;
    start_nxt       = start_r;
    beat_nxt        = beat_r;
    lin_nxt         = lin_r;
    addr_nxt        = addr_r;
    vld_nxt         = 1'b0;
    rdy_nxt         = rdy_r;
    gap_nxt         = gap_r;
    refill_done_nxt = refill_done_r;
    unique case (st_r)
      BRC_IDLE: begin
        rdy_nxt = 1'b1;
        // Latch on the first active edge or latch rise while selected.
        if (!cfg_r[RMS_BIT] && !ce_n_s && ((!l_n_s && act_edge) || latch_rise)) begin
          start_nxt       = a_s;
          lin_nxt         = a_s;
          beat_nxt        = 3'h0;
          cnt_nxt         = lat_cyc - 4'h1;
          refill_done_nxt = 1'b0;
          gap_nxt         = 1'b0;
          st_nxt          = BRC_LAT;
        end
      end
      BRC_LAT: begin
        if (act_edge) begin
          if (cnt_r == 4'h1) begin
            addr_nxt = seq_addr;
            vld_nxt  = 1'b1;
            st_nxt   = BRC_BURST;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
      end
      BRC_BURST: begin
        if (act_edge && !b_n_s) begin
          // Unaligned unbounded bursts pause once for the array refill.
          if (unbounded && !aligned8 && !refill_done_r && beat_r == 3'h0) begin
            if (!rdy_r) begin
              if (cnt_r == 4'h1) begin
                rdy_nxt         = 1'b1;
                refill_done_nxt = 1'b1;
              end else begin
                cnt_nxt = cnt_r - 4'h1;
              end
            end else begin
              rdy_nxt = 1'b0;
              cnt_nxt = REFILL_CYC;
            end
          end else if (rdy_r) begin
            if (cfg_r[IBL_BIT] && !gap_r) begin
              gap_nxt = 1'b1;
            end else begin
              gap_nxt  = 1'b0;
              beat_nxt = beat_r + 3'h1;
              lin_nxt  = next_lin;
              vld_nxt  = 1'b1;
              // Bounded bursts end after the last beat of the length.
              // No-wrap bursts of 4 or 8 still stop after their length.
              if ((blf != BLF_CONT) && (beat_nxt & len_mask) == len_mask) begin
                st_nxt = BRC_IDLE;
              end
            end
          end
        end
        if (st_r == BRC_BURST && vld_nxt) begin
          addr_nxt = unbounded ? next_lin : seq_addr;
        end
      end
      default: st_nxt = BRC_IDLE;
    endcase
    // Aligned unbounded bursts keep ready high throughout.
    if (unbounded && aligned8) begin
      rdy_nxt = 1'b1;
    end
    if (!rp_n_s || ce_n_s || cfg_r[RMS_BIT]) begin
      st_nxt  = BRC_IDLE;
      rdy_nxt = 1'b1;
      vld_nxt = 1'b0;
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_r         <= CFG_RESET;
      k_d_r         <= 1'b1;
      l_d_r         <= 1'b1;
      st_r          <= BRC_IDLE;
      cnt_r         <= 4'h0;
      start_r       <= '0;
      beat_r        <= 3'h0;
      lin_r         <= '0;
      addr_r        <= '0;
      vld_r         <= 1'b0;
      rdy_r         <= 1'b1;
      gap_r         <= 1'b0;
      refill_done_r <= 1'b0;
    end else begin
      cfg_r         <= cfg_nxt;
      k_d_r         <= k_s;
      l_d_r         <= l_n_s;
      st_r          <= st_nxt;
      cnt_r         <= cnt_nxt;
      start_r       <= start_nxt;
      beat_r        <= beat_nxt;
      lin_r         <= lin_nxt;
      addr_r        <= addr_nxt;
      vld_r         <= vld_nxt;
      rdy_r         <= rdy_nxt;
      gap_r         <= gap_nxt;
      refill_done_r <= refill_done_nxt;
    end
  end

  // ==========================================================================
  // Outputs. Early ready timing drops the pin as soon as the stall is known.
  assign burst_read_config_o = cfg_r;
  assign async_mode_o        = cfg_r[RMS_BIT];
  assign sig_cfg_sel_o       = sig_mode_i & (a_s == SIG_CFG_ADDR[AW-1:0]);
  assign beat_addr_o         = addr_r;
  assign beat_valid_o        = vld_r;
  assign data_ready_o        = cfg_r[RTS_BIT] ? (rdy_r & rdy_nxt) : rdy_r;
endmodule
`default_nettype wire

// [src/brc_pkg.sv]
// Purpose: Shared constants for the burst read configuration sequencer.
// Assumes: Configuration word is 16 bits; addresses are double-word indices.
// Notes:   Field positions and reset value of the configuration word.
package brc_pkg;
  // ==========================================================================
  // Configuration word layout
  localparam int          CFG_W          = 16;
  localparam int          RMS_BIT        = 15;
  localparam int          FAL_HI         = 13;
  localparam int          FAL_LO         = 11;
  localparam int          IBL_BIT        = 9;
  localparam int          RTS_BIT        = 8;
  localparam int          BOS_BIT        = 7;
  localparam int          CES_BIT        = 6;
  localparam int          WRD_BIT        = 3;
  localparam int          BLF_HI         = 2;
  localparam logic [15:0] CFG_RESET      = 16'h8000;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hBBCF;
  // ==========================================================================
  // Field encodings
  localparam logic [2:0]  FAL_RSVD       = 3'h1;
  localparam logic [2:0]  FAL_BASE       = 3'h2;
  localparam logic [3:0]  FAL_BASE_CYC   = 4'h4;
  localparam logic [2:0]  BLF_LEN4       = 3'h1;
  localparam logic [2:0]  BLF_LEN8       = 3'h2;
  localparam logic [2:0]  BLF_CONT       = 3'h7;
  localparam logic [18:0] SIG_CFG_ADDR   = 19'h00005;
  // ==========================================================================
  // Internal refill delay for unaligned continuous or no-wrap bursts
  localparam logic [3:0]  REFILL_CYC     = 4'h2;
endpackage

// [src/brc_sync2.sv]
// Purpose: Two flip-flop synchroniser for inputs from outside the clock domain.
// Assumes: Inputs are levels; output lags by two mclk_i edges.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module brc_sync2 #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         sys_rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;

  // ==========================================================================
  // Two stages guard against metastability on asynchronous pins.
  // Reset loads the idle pin levels so no false edge follows release.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_r <= RST;
      q_o  <= RST;
    end else begin
      s1_r <= d_i;
      q_o  <= s1_r;
    end
  end
endmodule
`default_nettype wire

// [tb/brc_sequencer_monitor.sv]
// Purpose: Port checker for the burst read configuration sequencer.
// Assumes: Pins stay steady for several mclk cycles around each change.
// Notes:   Bound into every sequencer instance after the module.
`timescale 1ns/1ps
`default_nettype none
module brc_sequencer_monitor #(
  parameter int AW = 19
) (
  // Clock, reset and inputs
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      reset_powerdown_n_i,
  input  wire logic [AW-1:0]             addr_i,
  input  wire logic                      cfg_wr_i,
  input  wire logic [brc_pkg::CFG_W-1:0] cfg_wdata_i,
  input  wire logic                      sig_mode_i,
  // Outputs
  input  wire logic [brc_pkg::CFG_W-1:0] burst_read_config_o,
  input  wire logic                      async_mode_o,
  input  wire logic                      sig_cfg_sel_o,
  input  wire logic                      beat_valid_o,
  input  wire logic                      data_ready_o
);
  // ==========================================================================
  // Checks; the pin synchroniser is why some rules wait four cycles.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_mode_bit: assert property (async_mode_o == burst_read_config_o[15])
    else $error("mode output differs from config bit");
  a_rsvd_zero: assert property ((burst_read_config_o & 16'h4430) == 16'h0000)
    else $error("reserved config bits not zero");
  a_cfg_hold: assert property ((reset_powerdown_n_i [*4] ##0 !cfg_wr_i) |=> $stable(burst_read_config_o))
    else $error("config changed without write");
  a_write_lands: assert property ((reset_powerdown_n_i [*4] ##0 cfg_wr_i) |=> burst_read_config_o == ($past(cfg_wdata_i) & 16'hBBCF))
    else $error("config write not applied");
  a_rp_restore: assert property (!reset_powerdown_n_i [*4] |-> burst_read_config_o == 16'h8000)
    else $error("power-down did not restore config");
  a_sig_hit: assert property ((sig_mode_i && addr_i == 'd5) [*4] |-> sig_cfg_sel_o)
    else $error("signature select missing");
  a_sig_gate: assert property (sig_cfg_sel_o |-> sig_mode_i)
    else $error("signature select outside mode");
  a_async_idle: assert property (async_mode_o [*4] |-> !beat_valid_o)
    else $error("beat in asynchronous mode");
  a_beat_gap: assert property (beat_valid_o |=> !beat_valid_o [*8])
    else $error("beats too close");
  a_stall_none: assert property ((!data_ready_o && !burst_read_config_o[8]) |-> !beat_valid_o)
    else $error("beat while ready low");
  c_beat: cover property (beat_valid_o);
  c_stall: cover property ($fell(data_ready_o));
  c_sig: cover property (sig_cfg_sel_o);
endmodule
bind brc_sequencer brc_sequencer_monitor #(.AW(AW)) u_mon (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reset_powerdown_n_i(reset_powerdown_n_i),
  .addr_i(addr_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .sig_mode_i(sig_mode_i),
  .burst_read_config_o(burst_read_config_o), .async_mode_o(async_mode_o),
  .sig_cfg_sel_o(sig_cfg_sel_o), .beat_valid_o(beat_valid_o), .data_ready_o(data_ready_o));
`default_nettype wire

// [tb/brc_ctrl_model.sv]
// Purpose: Burst bus controller model driving the burst pins.
// Assumes: Burst clock period 64 ns, parked high between frames.
// Notes:   A released address bus shows the inverse of the last address.
`timescale 1ns/1ps
`default_nettype none
module brc_ctrl_model (
  // Burst pins
  output logic        burst_clk_o,
  output logic        chip_en_n_o,
  output logic        latch_en_n_o,
  output logic        burst_adv_n_o,
  output logic [18:0] addr_o
);
  // ==========================================================================
  // Idle levels at time zero.
  initial begin
    burst_clk_o = 1'b1;
    chip_en_n_o = 1'b1;
    latch_en_n_o = 1'b1;
    burst_adv_n_o = 1'b1;
    addr_o = '1;
  end
  // One frame of n clock periods; address held past the latch edges.
  task automatic burst(input logic [18:0] a, input int n);
    #1.3;
    chip_en_n_o = 1'b0;
    latch_en_n_o = 1'b0;
    addr_o = a;
    for (int i = 0; i < 2 * n; i++) begin
      #32 burst_clk_o = ~burst_clk_o;
      if (i == 1) begin
        latch_en_n_o = 1'b1;
        burst_adv_n_o = 1'b0;
      end
      if (i == 3)
        addr_o = ~a;
    end
    #32 chip_en_n_o = 1'b1;
    burst_adv_n_o = 1'b1;
  endtask
  // Plain address for a signature read.
  task automatic put(input logic [18:0] a);
    addr_o = a;
  endtask
endmodule
`default_nettype wire

// [tb/brc_sequencer_test.sv]
// Purpose: Self-checking bench for the burst read configuration sequencer.
// Assumes: The controller model drives the burst pins.
// Notes:   Beat addresses are gathered during a frame and compared after.
`timescale 1ns/1ps
`default_nettype none
module brc_sequencer_test;
  import brc_pkg::*;
  logic        mclk_i;
  logic        sys_rst_i = 1'b1;
  logic        rp_n = 1'b1;
  logic        cfg_wr = 1'b0;
  logic        sig_mode = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [15:0] cfg_q;
  logic [18:0] addr, baddr;
  logic        k, ce_n, le_n, adv_n, async_q, sel_q, bval, rdy;
  logic        rdy_low = 1'b0;
  logic [18:0] got[$];
  int          kcnt = 0;
  int          first_k = 0;
  int          num_errors = 0;
  int          total_checks = 0;
  brc_ctrl_model mdl (.burst_clk_o(k), .chip_en_n_o(ce_n), .latch_en_n_o(le_n),
    .burst_adv_n_o(adv_n), .addr_o(addr));
  brc_sequencer #(.AW(19)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .burst_clk_i(k),
    .chip_en_n_i(ce_n), .latch_en_n_i(le_n), .burst_adv_n_i(adv_n),
    .reset_powerdown_n_i(rp_n), .addr_i(addr), .cfg_wr_i(cfg_wr), .cfg_wdata_i(cfg_wdata),
    .sig_mode_i(sig_mode), .burst_read_config_o(cfg_q), .async_mode_o(async_q),
    .sig_cfg_sel_o(sel_q), .beat_addr_o(baddr), .beat_valid_o(bval), .data_ready_o(rdy));
  // ==========================================================================
  // Clock, 4 ns period.
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // Gathers beats and notes any ready drop.
  always @(posedge mclk_i) begin
    if (bval === 1'b1) begin
      if (got.size() == 0)
        first_k = kcnt;
      got.push_back(baddr);
    end
    if (rdy === 1'b0)
      rdy_low = 1'b1;
  end
  // Counts active burst clock edges inside a frame.
  always @(k)
    if (ce_n === 1'b0 && k === cfg_q[CES_BIT])
      kcnt++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    cfg_wr <= 1'b1;
    cfg_wdata <= d;
    @(posedge mclk_i);
    cfg_wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  // Runs one frame; m picks interleaved, wrapped or linear expectations.
  task automatic run(input string nm, input logic [15:0] c, input logic [18:0] s,
                     input int n, input int m, input int l, input int nb, input int x);
    logic [18:0] e;
    wr(c);
    got.delete();
    rdy_low = 1'b0;
    kcnt = 0;
    mdl.burst(s, n);
    repeat (8) @(posedge mclk_i);
    check(first_k, x);
    if (l != 0)
      check(got.size(), nb);
    for (int i = 0; i < nb; i++) begin
      if (m == 0)
        e = (s & ~(l - 1)) | ((s & (l - 1)) ^ i);
      else if (m == 1)
        e = (s & ~(l - 1)) | ((s + i) & (l - 1));
      else
        e = s + i;
      check(got[i], e);
    end
    $display("test %s done", nm);
  endtask
  task automatic t_cfg;
    check(cfg_q, 16'h8000);
    wr(16'hFFFF);
    check(cfg_q, 16'hBBCF);
    wr(16'h10C1);
    repeat (4) @(posedge mclk_i);
    check(cfg_q, 16'h10C1);
    rp_n <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rp_n <= 1'b1;
    repeat (4) @(posedge mclk_i);
    check(cfg_q, 16'h8000);
    check(async_q, 1'b1);
    $display("test cfg done");
  endtask
  task automatic t_sig;
    mdl.put(19'h00005);
    sig_mode <= 1'b1;
    repeat (5) @(posedge mclk_i);
    check(sel_q, 1'b1);
    mdl.put(19'h00006);
    repeat (5) @(posedge mclk_i);
    check(sel_q, 1'b0);
    sig_mode <= 1'b0;
    $display("test sig done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset, then the scenarios; latency codes are all valid ones.
  initial begin
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    t_cfg();
    t_sig();
    run("wrap", 16'h10C1, 19'h00001, 12, 1, 4, 4, 4);
    run("inter", 16'h3202, 19'h00005, 28, 0, 8, 8, 8);
    run("cont", 16'h19C7, 19'h7FFF8, 17, 2, 0, 10, 5);
    check(rdy_low, 1'b0);
    run("nowrap", 16'h2089, 19'h00003, 16, 2, 4, 4, 6);
    check(rdy_low, 1'b1);
    end_sim();
  end
  // Hang guard.
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
